//--- ppfm_pkg.sv
package ppfm_pkg;
	localparam int PPFM_NUM_PADS = 16;
	localparam int PPFM_NUM_WAKE = 4;
	localparam int PPFM_NUM_SRC_FIELDS = 2;
	localparam int PPFM_SRC_SEL_W = 2;
	localparam logic [31:0] PPFM_ADDR_PAD_BASE = 32'h00000000;
	localparam logic [31:0] PPFM_ADDR_SRC_SEL = 32'h00000100;
	localparam logic [31:0] PPFM_ADDR_NMI_SEL = 32'h00000104;
	localparam logic [31:0] PPFM_ADDR_PAD_IN = 32'h00000108;
	localparam int PPFM_ALT_LSB = 0;
	localparam int PPFM_IBE_BIT = 2;
	localparam int PPFM_PULL_BIT = 3;
	localparam int PPFM_NMI_EN_BIT = 8;
	localparam logic [1:0] PPFM_AF_GPIO = 2'h0;
	localparam logic [1:0] PPFM_AF_JTAG = 2'h2;
	localparam logic [1:0] PPFM_RESP_OKAY = 2'h0;
	localparam logic [1:0] PPFM_RESP_SLVERR = 2'h2;
	localparam logic [3:0] PPFM_CFG_GPIO_RST = 4'h0;
	localparam logic [3:0] PPFM_CFG_JTAG_RST = 4'h6;
	localparam logic [3:0] PPFM_CFG_WAKE_RST = 4'hC;
	localparam int PPFM_PAD_TDI = 0;
	localparam int PPFM_PAD_TDO = 1;
	localparam int PPFM_PAD_TCK = 2;
	localparam int PPFM_PAD_TMS = 3;
	localparam int PPFM_WAKE_BASE = 12;
	typedef struct packed {
		logic pull_up;
		logic input_buffer_enable;
		logic [1:0] alt_func_select;
	} ppfm_pad_cfg_type;
	typedef enum logic [1:0] {
		PPFM_WR_IDLE = 2'b00,
		PPFM_WR_RESP = 2'b01
	} ppfm_wr_state_type;
	typedef enum logic [1:0] {
		PPFM_RD_IDLE = 2'b00,
		PPFM_RD_DATA = 2'b01
	} ppfm_rd_state_type;
endpackage

//--- ppfm_cfg_mem.sv
`timescale 1ns/10ps
`default_nettype none
module ppfm_cfg_mem import ppfm_pkg::*; #(
	parameter int NUM_PADS = PPFM_NUM_PADS
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic wr_en,
	input wire logic [$clog2(NUM_PADS)-1:0] wr_idx,
	input wire logic [3:0] wr_data,
	input wire logic [$clog2(NUM_PADS)-1:0] rd_idx,
	output logic [3:0] rd_data,
	output logic [NUM_PADS*4-1:0] cfg_flat
);
	logic [3:0] mem_reg [NUM_PADS];
	logic [3:0] mem_next [NUM_PADS];
	logic [3:0] rd_data_reg;
	logic [3:0] rd_data_next;
	function automatic logic [3:0] reset_cfg(input int idx);
		if (idx <= PPFM_PAD_TMS) begin
			return PPFM_CFG_JTAG_RST; // [RULE6]
		end else if (idx >= PPFM_WAKE_BASE) begin
			return PPFM_CFG_WAKE_RST; // [RULE9]
		end
		return PPFM_CFG_GPIO_RST; // [RULE6]
	endfunction
	always_comb begin
		for (int i = 0; i < NUM_PADS; i++) begin
			mem_next[i] = mem_reg[i];
			if (wr_en && (wr_idx == i[$clog2(NUM_PADS)-1:0])) begin
				mem_next[i] = wr_data;
			end
		end
		rd_data_next = mem_reg[rd_idx];
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < NUM_PADS; i++) begin
				mem_reg[i] <= reset_cfg(i);
			end
			rd_data_reg <= 4'h0;
		end else begin
			mem_reg <= mem_next;
			rd_data_reg <= rd_data_next;
		end
	end
	assign rd_data = rd_data_reg;
	genvar g;
	generate
		for (g = 0; g < NUM_PADS; g++) begin : g_flat
			assign cfg_flat[g*4 +: 4] = mem_reg[g];
		end
	endgenerate
endmodule
`default_nettype wire

//--- ppfm_top.sv
// Summary of operation
// RULE1 - The two-bit selector of each pad drives output slot 0, 1, 2 or 3 onto the pad for codes 00, 01, 10, 11.
// RULE2 - The selector steers outputs only, and a pad reaches input functions only while its input buffer is enabled; NMI_IN here takes the pad ungated.
// RULE3 - Input-only functions have no selector code, and enabling the input buffer alone selects them.
// RULE4 - An enabled pad input goes to every module that can use it, with source fields choosing among candidate pads.
// RULE5 - A pad picked as the non-maskable interrupt input overrides its selector, which is then ignored.
// RULE6 - After reset all pads are general purpose except four that default to the boundary-scan port.
// RULE7 - Software may give the boundary-scan pads to general use, giving up scan compliance.
// RULE8 - Every wake-up pad also feeds the interrupt logic as an external interrupt input.
// RULE9 - Every wake-up pad has its pull-up enabled by default.
// RULE10 - A pad with its input buffer off presents a fixed low to every peripheral input mapped to it; NMI_IN here takes the pad ungated.
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/10ps
`default_nettype none
module ppfm_top import ppfm_pkg::*; #(
	parameter int NUM_PADS = PPFM_NUM_PADS,
	parameter int NUM_WAKE = PPFM_NUM_WAKE
) (
	input wire logic SYS_CLK,
	input wire logic ARST_N,
	input wire logic [31:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [31:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	input wire logic [NUM_PADS-1:0] FUNCTION_SLOT_0,
	input wire logic [NUM_PADS-1:0] FUNCTION_SLOT_1,
	input wire logic [NUM_PADS-1:0] FUNCTION_SLOT_2,
	input wire logic [NUM_PADS-1:0] FUNCTION_SLOT_3,
	input wire logic [NUM_PADS-1:0] SLOT_0_OE,
	input wire logic [NUM_PADS-1:0] SLOT_1_OE,
	input wire logic [NUM_PADS-1:0] SLOT_2_OE,
	input wire logic [NUM_PADS-1:0] SLOT_3_OE,
	input wire logic [NUM_PADS-1:0] PAD_IN,
	output logic [NUM_PADS-1:0] PAD_OUT,
	output logic [NUM_PADS-1:0] PAD_OE,
	output logic [NUM_PADS-1:0] PAD_PULL_UP,
	output logic [NUM_PADS-1:0] PERIPH_IN,
	output logic [PPFM_NUM_SRC_FIELDS-1:0] SRC_SEL_IN,
	output logic [NUM_WAKE-1:0] EXT_IRQ_LINE,
	output logic NMI_IN
);
	localparam int IW = $clog2(NUM_PADS);
	// The pad input register is one bus word, so at most 32 pads
	if (NUM_PADS < 8 || NUM_PADS > 32 || NUM_WAKE > NUM_PADS - PPFM_WAKE_BASE || NUM_WAKE < 1) begin : g_bad_cfg
		$error("ppfm_top: unsupported pad or wake count");
	end
	logic rst_s1_reg, rst_s2_reg;
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			rst_s1_reg <= 1'b0;
			rst_s2_reg <= 1'b0;
		end else begin
			rst_s1_reg <= 1'b1;
			rst_s2_reg <= rst_s1_reg;
		end
	end
	logic rst_n;
	assign rst_n = rst_s2_reg;
	logic [NUM_PADS-1:0] pad_s1_reg, pad_s2_reg;
	always_ff @(posedge SYS_CLK or negedge rst_n) begin
		if (!rst_n) begin
			pad_s1_reg <= '0;
			pad_s2_reg <= '0;
		end else begin
			pad_s1_reg <= PAD_IN;
			pad_s2_reg <= pad_s1_reg;
		end
	end

	// Register bus
	ppfm_wr_state_type wr_state_reg, wr_state_next;
	ppfm_rd_state_type rd_state_reg, rd_state_next;
	logic [1:0] bresp_reg, bresp_next;
	logic [31:0] rdata_reg, rdata_next;
	logic [1:0] rresp_reg, rresp_next;
	logic [31:0] rd_addr_reg, rd_addr_next;
	logic rd_pend_reg, rd_pend_next;
	logic [PPFM_NUM_SRC_FIELDS*PPFM_SRC_SEL_W-1:0] src_sel_reg, src_sel_next;
	logic [8:0] nmi_sel_reg, nmi_sel_next;
	logic cfg_wr_en;
	logic [3:0] cfg_rd_data;
	logic [NUM_PADS*4-1:0] cfg_flat;

	function automatic logic is_pad_addr(input logic [31:0] a);
		return (a >= PPFM_ADDR_PAD_BASE) && (a < PPFM_ADDR_PAD_BASE + 32'(NUM_PADS * 4)) && (a[1:0] == 2'h0);
	endfunction
	logic wr_fire, aw_ready_reg, aw_ready_next, ar_ready_reg, ar_ready_next;
	// Readies come from flops, so address and data are taken one cycle after both valids rise
	assign wr_fire = (wr_state_reg == PPFM_WR_IDLE) && aw_ready_reg && S_AXI_AWVALID && S_AXI_WVALID;
	always_comb begin
		wr_state_next = wr_state_reg;
		aw_ready_next = (wr_state_reg == PPFM_WR_IDLE) && S_AXI_AWVALID && S_AXI_WVALID && !aw_ready_reg;
		bresp_next = bresp_reg;
		src_sel_next = src_sel_reg;
		nmi_sel_next = nmi_sel_reg;
		cfg_wr_en = 1'b0;
		case (wr_state_reg)
			PPFM_WR_IDLE: begin
				if (wr_fire) begin
					wr_state_next = PPFM_WR_RESP;
					bresp_next = PPFM_RESP_OKAY;
					if (is_pad_addr(S_AXI_AWADDR)) begin
						cfg_wr_en = S_AXI_WSTRB[0]; // [RULE7]
					end else if (S_AXI_AWADDR == PPFM_ADDR_SRC_SEL) begin
						if (S_AXI_WSTRB[0]) begin
							src_sel_next = S_AXI_WDATA[PPFM_NUM_SRC_FIELDS*PPFM_SRC_SEL_W-1:0];
						end
					end else if (S_AXI_AWADDR == PPFM_ADDR_NMI_SEL) begin
						if (S_AXI_WSTRB[0]) begin
							nmi_sel_next[7:0] = S_AXI_WDATA[7:0];
						end
						if (S_AXI_WSTRB[1]) begin
							nmi_sel_next[8] = S_AXI_WDATA[PPFM_NMI_EN_BIT];
						end
					end else if (S_AXI_AWADDR != PPFM_ADDR_PAD_IN) begin
						bresp_next = PPFM_RESP_SLVERR;
					end
				end
			end
			PPFM_WR_RESP: begin
				if (S_AXI_BREADY) begin
					wr_state_next = PPFM_WR_IDLE;
				end
			end
			default: wr_state_next = PPFM_WR_IDLE;
		endcase
	end
	always_comb begin
		rd_state_next = rd_state_reg;
		ar_ready_next = (rd_state_reg == PPFM_RD_IDLE) && S_AXI_ARVALID && !ar_ready_reg && !rd_pend_reg;
		rd_addr_next = rd_addr_reg;
		rd_pend_next = 1'b0;
		rdata_next = rdata_reg;
		rresp_next = rresp_reg;
		case (rd_state_reg)
			PPFM_RD_IDLE: begin
				if (ar_ready_reg && S_AXI_ARVALID) begin
					rd_addr_next = S_AXI_ARADDR;
					rd_pend_next = 1'b1;
				end
				if (rd_pend_reg) begin
					rd_state_next = PPFM_RD_DATA;
					rresp_next = PPFM_RESP_OKAY;
					rdata_next = 32'h00000000;
					if (is_pad_addr(rd_addr_reg)) begin
						rdata_next[3:0] = cfg_rd_data;
					end else if (rd_addr_reg == PPFM_ADDR_SRC_SEL) begin
						rdata_next[PPFM_NUM_SRC_FIELDS*PPFM_SRC_SEL_W-1:0] = src_sel_reg;
					end else if (rd_addr_reg == PPFM_ADDR_NMI_SEL) begin
						rdata_next[8:0] = nmi_sel_reg;
					end else if (rd_addr_reg == PPFM_ADDR_PAD_IN) begin
						rdata_next[NUM_PADS-1:0] = pad_s2_reg;
					end else begin
						rresp_next = PPFM_RESP_SLVERR;
					end
				end
			end
			PPFM_RD_DATA: begin
				if (S_AXI_RREADY) begin
					rd_state_next = PPFM_RD_IDLE;
				end
			end
			default: rd_state_next = PPFM_RD_IDLE;
		endcase
	end

	always_ff @(posedge SYS_CLK or negedge rst_n) begin
		if (!rst_n) begin
			wr_state_reg <= PPFM_WR_IDLE;
			rd_state_reg <= PPFM_RD_IDLE;
			bresp_reg <= PPFM_RESP_OKAY;
			rdata_reg <= 32'h00000000;
			rresp_reg <= PPFM_RESP_OKAY;
			rd_addr_reg <= 32'h00000000;
			rd_pend_reg <= 1'b0;
			aw_ready_reg <= 1'b0;
			ar_ready_reg <= 1'b0;
			src_sel_reg <= '0;
			nmi_sel_reg <= 9'h000;
		end else begin
			wr_state_reg <= wr_state_next;
			rd_state_reg <= rd_state_next;
			bresp_reg <= bresp_next;
			rdata_reg <= rdata_next;
			rresp_reg <= rresp_next;
			rd_addr_reg <= rd_addr_next;
			rd_pend_reg <= rd_pend_next;
			aw_ready_reg <= aw_ready_next;
			ar_ready_reg <= ar_ready_next;
			src_sel_reg <= src_sel_next;
			nmi_sel_reg <= nmi_sel_next;
		end
	end
	ppfm_cfg_mem #(
		.NUM_PADS(NUM_PADS)
	) u_cfg (
		.clk(SYS_CLK),
		.rst_n(rst_n),
		.wr_en(cfg_wr_en),
		.wr_idx(S_AXI_AWADDR[IW+1:2]),
		.wr_data(S_AXI_WDATA[3:0]),
		.rd_idx(S_AXI_ARADDR[IW+1:2]),
		.rd_data(cfg_rd_data),
		.cfg_flat(cfg_flat)
	);

	// Pad mux datapath
	logic [NUM_PADS-1:0] pad_out_reg, pad_out_next;
	logic [NUM_PADS-1:0] pad_oe_reg, pad_oe_next;
	logic [NUM_PADS-1:0] pull_reg, pull_next;
	logic [NUM_PADS-1:0] periph_reg, periph_next;
	logic [PPFM_NUM_SRC_FIELDS-1:0] src_in_reg, src_in_next;
	logic [NUM_WAKE-1:0] irq_reg, irq_next;
	logic nmi_reg, nmi_next;
	logic [NUM_PADS-1:0] gated_in;
	logic [NUM_PADS-1:0] nmi_pad;

	genvar g;
	generate
		for (g = 0; g < NUM_PADS; g++) begin : g_pad
			ppfm_pad_cfg_type cfg;
			assign cfg = ppfm_pad_cfg_type'(cfg_flat[g*4 +: 4]);
			assign nmi_pad[g] = nmi_sel_reg[PPFM_NMI_EN_BIT] && (nmi_sel_reg[7:0] == 8'(g));
			assign gated_in[g] = cfg.input_buffer_enable & pad_s2_reg[g]; // [RULE2] [RULE3] [RULE10]
			always_comb begin
				pull_next[g] = cfg.pull_up;
				if (nmi_pad[g]) begin
					pad_out_next[g] = 1'b0; // [RULE5]
					pad_oe_next[g] = 1'b0;
				end else begin
					case (cfg.alt_func_select) // [RULE1]
						2'h0: begin
							pad_out_next[g] = FUNCTION_SLOT_0[g];
							pad_oe_next[g] = SLOT_0_OE[g];
						end
						2'h1: begin
							pad_out_next[g] = FUNCTION_SLOT_1[g];
							pad_oe_next[g] = SLOT_1_OE[g];
						end
						2'h2: begin
							pad_out_next[g] = FUNCTION_SLOT_2[g];
							pad_oe_next[g] = SLOT_2_OE[g];
						end
						default: begin
							pad_out_next[g] = FUNCTION_SLOT_3[g];
							pad_oe_next[g] = SLOT_3_OE[g];
						end
					endcase
				end
			end
		end
		for (g = 0; g < PPFM_NUM_SRC_FIELDS; g++) begin : g_src
			assign src_in_next[g] = gated_in[g*4 + 4 + src_sel_reg[g*PPFM_SRC_SEL_W +: PPFM_SRC_SEL_W]]; // [RULE4]
		end
		for (g = 0; g < NUM_WAKE; g++) begin : g_wake
			assign irq_next[g] = gated_in[PPFM_WAKE_BASE + g]; // [RULE8]
		end
	endgenerate

	assign periph_next = gated_in; // [RULE4]
	assign nmi_next = |(nmi_pad & pad_s2_reg); // [RULE5]

	always_ff @(posedge SYS_CLK or negedge rst_n) begin
		if (!rst_n) begin
			pad_out_reg <= '0;
			pad_oe_reg <= '0;
			pull_reg <= '0;
			periph_reg <= '0;
			src_in_reg <= '0;
			irq_reg <= '0;
			nmi_reg <= 1'b0;
		end else begin
			pad_out_reg <= pad_out_next;
			pad_oe_reg <= pad_oe_next;
			pull_reg <= pull_next;
			periph_reg <= periph_next;
			src_in_reg <= src_in_next;
			irq_reg <= irq_next;
			nmi_reg <= nmi_next;
		end
	end

	assign S_AXI_AWREADY = aw_ready_reg;
	assign S_AXI_WREADY = aw_ready_reg;
	assign S_AXI_BVALID = wr_state_reg[0];
	assign S_AXI_BRESP = bresp_reg;
	assign S_AXI_ARREADY = ar_ready_reg;
	assign S_AXI_RVALID = rd_state_reg[0];
	assign S_AXI_RDATA = rdata_reg;
	assign S_AXI_RRESP = rresp_reg;
	assign PAD_OUT = pad_out_reg;
	assign PAD_OE = pad_oe_reg;
	assign PAD_PULL_UP = pull_reg;
	assign PERIPH_IN = periph_reg;
	assign SRC_SEL_IN = src_in_reg;
	assign EXT_IRQ_LINE = irq_reg;
	assign NMI_IN = nmi_reg;

	a_slot_route: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
		!nmi_pad[5] && cfg_flat[5*4 +: 2] == 2'h1 |=> PAD_OUT[5] == $past(FUNCTION_SLOT_1[5])) // [RULE1]
		else $error("slot 1 not routed");
	a_ibe_gate: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
		!cfg_flat[6*4 + PPFM_IBE_BIT] |=> !PERIPH_IN[6]) // [RULE2]
		else $error("input passed while buffer off");
	a_ibe_only: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
		cfg_flat[7*4 + PPFM_IBE_BIT] |=> PERIPH_IN[7] == $past(pad_s2_reg[7])) // [RULE3]
		else $error("input not delivered");
	a_fanout: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
		src_sel_reg[1:0] == 2'h0 |=> SRC_SEL_IN[0] == $past(gated_in[4])) // [RULE4]
		else $error("source select wrong");
	a_nmi_over: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
		nmi_pad[8] |=> !PAD_OE[8]) // [RULE5]
		else $error("nmi pad driven");
	a_reset_jtag: assert property (@(posedge SYS_CLK) $rose(rst_n) |-> cfg_flat[PPFM_PAD_TCK*4 +: 2] == PPFM_AF_JTAG) // [RULE6]
		else $error("scan pad not default");
	a_wake_irq: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
		1'b1 |=> EXT_IRQ_LINE[0] == $past(gated_in[PPFM_WAKE_BASE])) // [RULE8]
		else $error("wake irq mismatch");
	a_wake_pull: assert property (@(posedge SYS_CLK) $rose(rst_n) |=> PAD_PULL_UP[PPFM_WAKE_BASE]) // [RULE9]
		else $error("wake pull-up off");
	a_float_low: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
		!cfg_flat[PPFM_WAKE_BASE*4 + PPFM_IBE_BIT] [*2] |-> !EXT_IRQ_LINE[0]) // [RULE10]
		else $error("floating pad leaked");
endmodule
`default_nettype wire

//--- ppfm_pad_model.sv
`timescale 1ns/10ps
`default_nettype none
module ppfm_pad_model import ppfm_pkg::*; (
	input wire logic clk,
	input wire logic [PPFM_NUM_PADS-1:0] pad_out,
	input wire logic [PPFM_NUM_PADS-1:0] pad_oe,
	input wire logic [PPFM_NUM_PADS-1:0] pad_pull_up,
	input wire logic [PPFM_NUM_PADS-1:0] ext_en,
	input wire logic [PPFM_NUM_PADS-1:0] ext_lvl,
	output logic [PPFM_NUM_PADS-1:0] pad_wire
);
	logic [PPFM_NUM_PADS-1:0] wander_reg = '0;
	// A floating pad without pull-up shows a level that changes every cycle
	always_ff @(posedge clk) begin
		wander_reg <= ~wander_reg;
	end
	// Device drive wins, then the external driver, then the pull-up
	always_comb begin
		for (int i = 0; i < PPFM_NUM_PADS; i++) begin
			if (pad_oe[i] === 1'b1) begin
				pad_wire[i] = pad_out[i];
			end else if (ext_en[i] === 1'b1) begin
				pad_wire[i] = ext_lvl[i];
			end else if (pad_pull_up[i] === 1'b1) begin
				pad_wire[i] = 1'b1;
			end else begin
				pad_wire[i] = wander_reg[i];
			end
		end
	end
endmodule
`default_nettype wire

//--- tb_port_pad_function_mux.sv
`timescale 1ns/10ps
`default_nettype none
module tb_port_pad_function_mux import ppfm_pkg::*; ;
	logic clk, arst_n, aw_valid, w_valid, ar_valid, b_ready, r_ready;
	logic aw_ready, w_ready, b_valid, ar_ready, r_valid, nmi_in, nmi_on;
	logic [31:0] aw_addr, w_data, ar_addr, r_data, seed;
	logic [3:0] w_strb, src, nmi_pad, irq_line;
	logic [1:0] b_resp, r_resp, src_in;
	logic [15:0] fs [4];
	logic [15:0] fo [4];
	logic [15:0] ext_en, ext_lvl, pad_wire, pad_out, pad_oe, pad_pu, periph_in;
	logic [15:0] e_out, e_oe, e_pu, e_in, e_wire, known, gmask;
	logic [3:0] cfg [16];
	int bad_count, total_checks;

	ppfm_top ppfm_top_i (
		.SYS_CLK(clk), .ARST_N(arst_n),
		.S_AXI_AWADDR(aw_addr), .S_AXI_AWVALID(aw_valid), .S_AXI_AWREADY(aw_ready),
		.S_AXI_WDATA(w_data), .S_AXI_WSTRB(w_strb), .S_AXI_WVALID(w_valid), .S_AXI_WREADY(w_ready),
		.S_AXI_BRESP(b_resp), .S_AXI_BVALID(b_valid), .S_AXI_BREADY(b_ready),
		.S_AXI_ARADDR(ar_addr), .S_AXI_ARVALID(ar_valid), .S_AXI_ARREADY(ar_ready),
		.S_AXI_RDATA(r_data), .S_AXI_RRESP(r_resp), .S_AXI_RVALID(r_valid), .S_AXI_RREADY(r_ready),
		.FUNCTION_SLOT_0(fs[0]), .FUNCTION_SLOT_1(fs[1]), .FUNCTION_SLOT_2(fs[2]), .FUNCTION_SLOT_3(fs[3]),
		.SLOT_0_OE(fo[0]), .SLOT_1_OE(fo[1]), .SLOT_2_OE(fo[2]), .SLOT_3_OE(fo[3]),
		.PAD_IN(pad_wire), .PAD_OUT(pad_out), .PAD_OE(pad_oe), .PAD_PULL_UP(pad_pu),
		.PERIPH_IN(periph_in), .SRC_SEL_IN(src_in), .EXT_IRQ_LINE(irq_line), .NMI_IN(nmi_in)
	);

	ppfm_pad_model ppfm_pad_model_i (
		.clk(clk), .pad_out(pad_out), .pad_oe(pad_oe), .pad_pull_up(pad_pu),
		.ext_en(ext_en), .ext_lvl(ext_lvl), .pad_wire(pad_wire)
	);

	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	function automatic logic [3:0] rst_cfg(input int n);
		if (n < 4) begin
			return 4'h6;
		end
		return (n >= 12) ? 4'hC : 4'h0;
	endfunction

	// Expected pad drive and gated inputs; known marks defined pad levels, gmask defined gated inputs
	function automatic void model();
		logic [1:0] s;
		for (int n = 0; n < 16; n++) begin
			s = cfg[n][1:0];
			e_oe[n] = fo[s][n] & ~(nmi_on && nmi_pad == 4'(n));
			e_out[n] = fs[s][n];
			e_pu[n] = cfg[n][3];
			known[n] = e_oe[n] | ext_en[n] | cfg[n][3];
			gmask[n] = known[n] | ~cfg[n][2];
			e_wire[n] = e_oe[n] ? e_out[n] : (ext_en[n] ? ext_lvl[n] : 1'b1);
			e_in[n] = e_wire[n] & cfg[n][2];
		end
	endfunction

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic test_done();
		$display("checks=%0d mismatches=%0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
		aw_addr <= a;
		w_data <= d;
		aw_valid <= 1'b1;
		w_valid <= 1'b1;
		@(posedge clk);
		while (!(aw_ready === 1'b1 && w_ready === 1'b1)) @(posedge clk);
		aw_valid <= 1'b0;
		w_valid <= 1'b0;
		@(posedge clk);
		while (b_valid !== 1'b1) @(posedge clk);
		r = b_resp;
	endtask

	task automatic axi_rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
		ar_addr <= a;
		ar_valid <= 1'b1;
		@(posedge clk);
		while (ar_ready !== 1'b1) @(posedge clk);
		ar_valid <= 1'b0;
		@(posedge clk);
		while (r_valid !== 1'b1) @(posedge clk);
		d = r_data;
		r = r_resp;
	endtask

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	initial begin
		repeat (20000) @(posedge clk);
		bad_count++;
		test_done();
	end

	initial begin
		logic [31:0] d;
		logic [1:0] r;
		logic [3:0] idx;
		seed = 32'h0001428D;
		bad_count = 0;
		total_checks = 0;
		arst_n = 1'b0;
		aw_valid = 1'b0;
		w_valid = 1'b0;
		ar_valid = 1'b0;
		b_ready = 1'b1;
		r_ready = 1'b1;
		aw_addr = 32'h00000000;
		w_data = 32'h00000000;
		ar_addr = 32'h00000000;
		w_strb = 4'hF;
		ext_en = 16'h0000;
		ext_lvl = 16'h0000;
		nmi_on = 1'b0;
		nmi_pad = 4'h0;
		src = 4'h0;
		for (int s = 0; s < 4; s++) begin
			fs[s] = 16'h0000;
			fo[s] = 16'h0000;
		end
		repeat (2) @(posedge clk);
		arst_n <= 1'b1;
		repeat (4) @(posedge clk);
		for (int n = 0; n < 16; n++) begin
			axi_rd(32'(4 * n), d, r);
			chk(d, {28'h0, rst_cfg(n)});
		end
		chk({16'h0, pad_pu}, 32'h0000F000);
		axi_rd(32'h00000200, d, r);
		chk({30'h0, r}, {30'h0, PPFM_RESP_SLVERR});
		// A pad write without its low byte strobe leaves the reset value in place
		w_strb <= 4'hE;
		axi_wr(32'h0000001C, 32'h00000003, r);
		w_strb <= 4'hF;
		chk({30'h0, r}, {30'h0, PPFM_RESP_OKAY});
		axi_rd(32'h0000001C, d, r);
		chk(d, {28'h0, rst_cfg(7)});
		for (int it = 0; it < 40; it++) begin
			for (int n = 0; n < 16; n++) begin
				cfg[n] = 4'(rnd());
				if (it == 0) begin
					cfg[n][1:0] = 2'h0;
				end
				if (it == 1) begin
					cfg[n][2] = 1'b0;
				end
				axi_wr(32'(4 * n), {28'h0, cfg[n]}, r);
				chk({30'h0, r}, {30'h0, PPFM_RESP_OKAY});
			end
			src = 4'(rnd());
			nmi_pad = 4'(rnd());
			nmi_on = 1'(rnd());
			axi_wr(PPFM_ADDR_SRC_SEL, {28'h0, src}, r);
			chk({30'h0, r}, {30'h0, PPFM_RESP_OKAY});
			axi_wr(PPFM_ADDR_NMI_SEL, {23'h0, nmi_on, 4'h0, nmi_pad}, r);
			chk({30'h0, r}, {30'h0, PPFM_RESP_OKAY});
			for (int s = 0; s < 4; s++) begin
				fs[s] <= 16'(rnd());
				fo[s] <= 16'(rnd());
			end
			ext_en <= 16'(rnd());
			ext_lvl <= 16'(rnd());
			repeat (8) @(posedge clk);
			model();
			axi_rd(32'(4 * (it % 16)), d, r);
			chk(d, {28'h0, cfg[it % 16]});
			chk({16'h0, pad_oe}, {16'h0, e_oe});
			chk({16'h0, pad_out & e_oe}, {16'h0, e_out & e_oe});
			chk({16'h0, pad_pu}, {16'h0, e_pu});
			chk({16'h0, periph_in & gmask}, {16'h0, e_in & gmask});
			chk({28'h0, irq_line & gmask[15:12]}, {28'h0, e_in[15:12] & gmask[15:12]});
			for (int k = 0; k < 2; k++) begin
				idx = 4'(4 + 4 * k) + {2'h0, src[2 * k +: 2]};
				chk({31'h0, src_in[k] & gmask[idx]}, {31'h0, e_in[idx] & gmask[idx]});
			end
			if (nmi_on === 1'b1) begin
				chk({31'h0, nmi_in & known[nmi_pad]}, {31'h0, e_wire[nmi_pad] & known[nmi_pad]});
			end
		end
		test_done();
	end
endmodule
`default_nettype wire
